// file: inc/porta_map.svh
// register offsets, reset values and timing counts of the port a pin logic
`ifndef PORTA_MAP_SVH
`define PORTA_MAP_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define PA_OFF_DATA 5'h00
`define PA_OFF_DIR 5'h04
`define PA_OFF_C1MASK 5'h08
`define PA_OFF_C1DATA 5'h0C
`define PA_OFF_MODE 5'h10
`define PA_OFF_FORCE 5'h14

// ****************************************************************
// field positions
// ****************************************************************
`define PA_OUT_LSB 3
`define PA_OUT_MSB 7
`define PA_DIR_BIT 7

// ****************************************************************
// reset values
// ****************************************************************
`define PA_RST_GP 5'h00
`define PA_RST_DIR 1'h0
`define PA_RST_C1MASK 5'h00
`define PA_RST_C1DATA 5'h00
`define PA_RST_MODE 8'h00
`define PA_RST_PIN 4'h0

// ****************************************************************
// timing: bus e clock is clock_i divided by four
// ****************************************************************
`define PA_PHASE_PH2_FALL 2'h1
`define PA_PHASE_E_FALL 2'h3

`endif

// file: inc/porta_pkg.sv
// types and the compare next-level function of the port a pin logic
`default_nettype none

package porta_pkg;

    typedef logic [1:0] phase_t;
    typedef logic [1:0] mode_level_t;

    // encoding of one compare mode/level field
    typedef enum logic [1:0]
    {
        ACT_OFF = 2'h0,
        ACT_TOGGLE = 2'h1,
        ACT_LOW = 2'h2,
        ACT_HIGH = 2'h3
    } compare_action_e;

    // next pin level from mode/level field and previous level
    function automatic logic next_level(input mode_level_t ml, input logic prev);
        compare_action_e act;
        act = compare_action_e'(ml);
        unique case (act)
            ACT_OFF: next_level = prev;
            ACT_TOGGLE: next_level = ~prev;
            ACT_LOW: next_level = 1'b0;
            ACT_HIGH: next_level = 1'b1;
        endcase
    endfunction : next_level

endpackage : porta_pkg

`default_nettype wire

// file: src/half_flip_flop.sv
// half flip-flop: transparent while gate is high, holding while gate is low
`default_nettype none

module half_flip_flop #(
    parameter int WIDTH = 5,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    input wire logic gate_i,
    input wire logic [WIDTH-1:0] d_i,
    output logic [WIDTH-1:0] q_o
);

    logic [WIDTH-1:0] hold_q;
    logic [WIDTH-1:0] hold_d;

    // pass through while gated, else show the held value
    always_comb
    begin
        q_o = (gate_i && ce_i) ? d_i : hold_q;
        hold_d = q_o;
    end

    // holding stage; reset value stands in for the optional set/reset
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
            hold_q <= RESET_VALUE;
        else if (ce_i)
            hold_q <= hold_d;
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    a_hff_pass: assert property (
        @(posedge clock_i) disable iff (!resetn_i)
        gate_i && ce_i |-> q_o == d_i)
        else $error("half flip-flop not transparent while gated");
    a_hff_hold: assert property (
        @(posedge clock_i) disable iff (!resetn_i)
        !(gate_i && ce_i) |-> $stable(q_o))
        else $error("half flip-flop output moved while holding");

endmodule : half_flip_flop

`default_nettype wire

// file: src/port_a_timer_pin_logic.sv
// port a pin logic shared with compare, capture and pulse-accumulator functions
//
// Overview of operation
// - half flip-flop passes when gated, else holds
// - bits 0-2 read buffered pins, capture-independent
// - bits 3-6 read driven output, not pin
// - pins 3-6 pick latch, own compare, compare1
// - latch drives pin only when untimed, strobed
// - compare1 mask set gives compare1 control
// - nonzero mode field gives own compare control
// - compare1 event loads mask-enabled pins with data
// - compare event uses mode, level, previous pin
// - previous pin state held stable during update
// - bit 7 read is always buffered pin
// - pin 7 drives only with direction one
// - pin 7 unmasked takes latch; reset clears
// - pin 7 masked loads compare1 data bit
// - direction change lands at phase-two fall
// - latch written even while pin is input
// - reset clears direction to input
`include "porta_map.svh"
`default_nettype none

module port_a_timer_pin_logic (
    input wire logic clock_i,
    input wire logic resetn_i,
    input wire logic ce_i,
    // avalon-mm slave
    input wire logic [4:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [3:0] avs_byteenable_i,
    output logic [31:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // timer side, same clock
    input wire logic compare1_match_i,
    input wire logic [3:0] compare_x_match_i,
    output logic [2:0] capture_pin_o,
    output logic pulse_accumulator_input_o,
    // pins
    input wire logic [2:0] pin_in_i,
    output logic [3:0] pin_out_o,
    input wire logic port_pin_seven_i,
    output logic port_pin_seven_o,
    output logic port_pin_seven_oe_o
);

    import porta_pkg::*;

    // ****************************************************************
    // pin synchronizers
    // ****************************************************************
    logic [3:0] raw_in;
    logic [3:0] meta_q;
    logic [3:0] sync_q;

    assign raw_in = {port_pin_seven_i, pin_in_i};

    // two stages per input; first stage is read by the second only
    for (genvar g = 0; g < 4; g++)
    begin : g_sync
        always_ff @(posedge clock_i or negedge resetn_i)
        begin
            if (!resetn_i)
            begin
                meta_q[g] <= 1'b0;
                sync_q[g] <= 1'b0;
            end
            else if (ce_i)
            begin
                meta_q[g] <= raw_in[g];
                sync_q[g] <= meta_q[g];
            end
        end
    end

    // capture and accumulator see the same buffered level as reads
    assign capture_pin_o = sync_q[2:0];
    assign pulse_accumulator_input_o = sync_q[3];

    // ****************************************************************
    // e clock phase and strobes
    // ****************************************************************
    phase_t phase_q;
    phase_t phase_d;
    logic port_sync_strobe;
    logic phase_two_fall;

    // free-running divider; strobes are decodes of one flop group
    always_comb
    begin
        phase_d = phase_q + 2'h1;
    end

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
            phase_q <= 2'h0;
        else if (ce_i)
            phase_q <= phase_d;
    end

    assign port_sync_strobe = ce_i && (phase_q == `PA_PHASE_E_FALL);
    assign phase_two_fall = ce_i && (phase_q == `PA_PHASE_PH2_FALL);

    // ****************************************************************
    // register bus
    // ****************************************************************
    logic wait_q;
    logic wait_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic wr_take;
    logic rd_take;
    logic lane0;
    logic [7:0] rbyte;
    logic [7:0] wbyte;

    logic pin_seven_direction_q;
    logic pin_seven_direction_d;
    logic [4:0] compare1_pin_mask_q;
    logic [4:0] compare1_pin_mask_d;
    logic [4:0] compare1_pin_data_q;
    logic [4:0] compare1_pin_data_d;
    logic [7:0] mode_q;
    logic [7:0] mode_d;
    logic [4:0] gp_latch;
    logic gp_write;
    logic [3:0] pin_q;
    logic [3:0] pin_d;

    // one wait cycle per access: request seen, then answered
    assign wr_take = avs_write_i && !wait_q;
    assign rd_take = avs_read_i && wait_q;
    assign lane0 = avs_byteenable_i[0];
    assign wbyte = avs_writedata_i[7:0];
    assign gp_write = wr_take && lane0 && (avs_address_i == `PA_OFF_DATA);

    // read mux; force register reads as zero, unmapped reads zero
    always_comb
    begin
        rbyte = 8'h00;
        unique case (avs_address_i)
            `PA_OFF_DATA: rbyte = {sync_q[3], pin_q, sync_q[2:0]};
            `PA_OFF_DIR: rbyte = {pin_seven_direction_q, 7'h00};
            `PA_OFF_C1MASK: rbyte = {compare1_pin_mask_q, 3'h0};
            `PA_OFF_C1DATA: rbyte = {compare1_pin_data_q, 3'h0};
            `PA_OFF_MODE: rbyte = mode_q;
            default: rbyte = 8'h00;
        endcase
        wait_d = !((avs_read_i || avs_write_i) && wait_q);
        rdata_d = rd_take ? {24'h000000, rbyte} : rdata_q;
    end

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            wait_q <= 1'b1;
            rdata_q <= 32'h00000000;
        end
        else if (ce_i)
        begin
            wait_q <= wait_d;
            rdata_q <= rdata_d;
        end
    end

    assign avs_waitrequest_o = wait_q;
    assign avs_readdata_o = rdata_q;

    // configuration writes; direction resets to input
    always_comb
    begin
        pin_seven_direction_d = pin_seven_direction_q;
        compare1_pin_mask_d = compare1_pin_mask_q;
        compare1_pin_data_d = compare1_pin_data_q;
        mode_d = mode_q;
        if (wr_take && lane0)
        begin
            unique case (avs_address_i)
                `PA_OFF_DIR: pin_seven_direction_d = wbyte[`PA_DIR_BIT];
                `PA_OFF_C1MASK: compare1_pin_mask_d = wbyte[`PA_OUT_MSB:`PA_OUT_LSB];
                `PA_OFF_C1DATA: compare1_pin_data_d = wbyte[`PA_OUT_MSB:`PA_OUT_LSB];
                `PA_OFF_MODE: mode_d = wbyte;
                default: mode_d = mode_q;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pin_seven_direction_q <= `PA_RST_DIR;
            compare1_pin_mask_q <= `PA_RST_C1MASK;
            compare1_pin_data_q <= `PA_RST_C1DATA;
            mode_q <= `PA_RST_MODE;
        end
        else if (ce_i)
        begin
            pin_seven_direction_q <= pin_seven_direction_d;
            compare1_pin_mask_q <= compare1_pin_mask_d;
            compare1_pin_data_q <= compare1_pin_data_d;
            mode_q <= mode_d;
        end
    end

    // general-purpose latch loads on any data write with byte lane 0 enabled, output or not
    half_flip_flop #(
        .WIDTH(5),
        .RESET_VALUE(`PA_RST_GP)
    ) u_gp_latch (
        .clock_i(clock_i),
        .resetn_i(resetn_i),
        .ce_i(ce_i),
        .gate_i(gp_write),
        .d_i(wbyte[`PA_OUT_MSB:`PA_OUT_LSB]),
        .q_o(gp_latch)
    );

    // ****************************************************************
    // compare events, held until the next e fall
    // ****************************************************************
    logic pend1_q;
    logic pend1_d;
    logic [3:0] pendx_q;
    logic [3:0] pendx_d;
    logic force_wr;
    logic evt1;
    logic [3:0] evtx;

    assign force_wr = wr_take && lane0 && (avs_address_i == `PA_OFF_FORCE);

    // an event arriving on the strobe cycle is used then, never lost
    always_comb
    begin
        evt1 = pend1_q || compare1_match_i || (force_wr && wbyte[7]);
        evtx = pendx_q | compare_x_match_i | (force_wr ? wbyte[6:3] : 4'h0);
        pend1_d = port_sync_strobe ? 1'b0 : evt1;
        pendx_d = port_sync_strobe ? 4'h0 : evtx;
    end

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pend1_q <= 1'b0;
            pendx_q <= 4'h0;
        end
        else if (ce_i)
        begin
            pend1_q <= pend1_d;
            pendx_q <= pendx_d;
        end
    end

    // ****************************************************************
    // pins 3 to 6 output selection
    // ****************************************************************
    logic [3:0] timed;

    // per pin: compare1, then own compare, then latch
    for (genvar p = 0; p < 4; p++)
    begin : g_out
        mode_level_t ml;
        assign ml = mode_q[2*p+1:2*p];
        assign timed[p] = compare1_pin_mask_q[p] || (ml != 2'h0);
        always_comb
        begin
            pin_d[p] = pin_q[p];
            if (port_sync_strobe)
            begin
                if (compare1_pin_mask_q[p] && evt1)
                    pin_d[p] = compare1_pin_data_q[p];
                else if ((ml != 2'h0) && evtx[p])
                    pin_d[p] = next_level(ml, pin_q[p]);
                else if (!timed[p])
                    pin_d[p] = gp_latch[p];
            end
        end
    end

    // pin_q doubles as the stable previous state during an update
    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
            pin_q <= `PA_RST_PIN;
        else if (ce_i)
            pin_q <= pin_d;
    end

    assign pin_out_o = pin_q;

    // ****************************************************************
    // pin 7 data and driver enable
    // ****************************************************************
    logic pin7_q;
    logic pin7_d;
    logic oe7_q;
    logic oe7_d;

    // data moves at e fall, the driver enable at phase-two fall
    always_comb
    begin
        pin7_d = pin7_q;
        oe7_d = oe7_q;
        if (port_sync_strobe)
        begin
            if (!compare1_pin_mask_q[4])
                pin7_d = gp_latch[4];
            else if (evt1)
                pin7_d = compare1_pin_data_q[4];
        end
        if (phase_two_fall)
            oe7_d = pin_seven_direction_q;
    end

    always_ff @(posedge clock_i or negedge resetn_i)
    begin
        if (!resetn_i)
        begin
            pin7_q <= 1'b0;
            oe7_q <= 1'b0;
        end
        else if (ce_i)
        begin
            pin7_q <= pin7_d;
            oe7_q <= oe7_d;
        end
    end

    assign port_pin_seven_o = pin7_q;
    assign port_pin_seven_oe_o = oe7_q;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!resetn_i);

    a_wait_one_cycle: assert property (
        (avs_read_i || avs_write_i) && wait_q && ce_i |=> !avs_waitrequest_o)
        else $error("bus access not answered after one wait cycle");
    a_pins_only_strobe: assert property (
        ce_i && !port_sync_strobe |=> $stable(pin_out_o))
        else $error("pins 3-6 changed away from the e fall strobe");
    a_latch_path: assert property (
        port_sync_strobe && !compare1_pin_mask_q[0] && mode_q[1:0] == 2'h0
        |=> pin_out_o[0] == $past(gp_latch[0]))
        else $error("untimed pin 3 did not take the latch");
    a_c1_override: assert property (
        port_sync_strobe && evt1 && evtx[0] && compare1_pin_mask_q[0]
        |=> pin_out_o[0] == $past(compare1_pin_data_q[0]))
        else $error("compare1 did not override on pin 3");
    a_toggle_mode: assert property (
        port_sync_strobe && evtx[1] && !compare1_pin_mask_q[1] && mode_q[3:2] == 2'h1
        |=> pin_out_o[1] != $past(pin_out_o[1]))
        else $error("toggle mode did not invert pin 4");
    a_read_inputs: assert property (
        rd_take && ce_i && avs_address_i == `PA_OFF_DATA
        |=> avs_readdata_o[2:0] == $past(sync_q[2:0]))
        else $error("read of bits 0-2 is not the buffered pins");
    a_read_outbuf: assert property (
        rd_take && ce_i && avs_address_i == `PA_OFF_DATA
        |=> avs_readdata_o[6:3] == $past(pin_out_o))
        else $error("read of bits 3-6 is not the output state");
    a_dir_ph2: assert property (
        phase_two_fall |=> port_pin_seven_oe_o == $past(pin_seven_direction_q))
        else $error("pin 7 enable missed the phase-two fall");
    a_pin7_hiz: assert property (
        (!pin_seven_direction_q && ce_i) [*5] |-> !port_pin_seven_oe_o)
        else $error("pin 7 driven with direction zero");
    a_pin7_masked: assert property (
        port_sync_strobe && compare1_pin_mask_q[4] && evt1
        |=> port_pin_seven_o == $past(compare1_pin_data_q[4]))
        else $error("masked pin 7 did not load compare1 data");

endmodule : port_a_timer_pin_logic

`default_nettype wire

// file: verification/board_pins.sv
// board-side model of the port a pins
`default_nettype none

module board_pins (
    input wire logic clock_i,
    input wire logic drive_i,
    input wire logic oe_i,
    input wire logic board_en_i,
    input wire logic board_val_i,
    input wire logic [2:0] low_val_i,
    output logic pin_seven_o,
    output logic [2:0] low_pins_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic last_q = 1'b0;

    // pin 7 has no pull: with nobody driving it shows the inverse of its last level
    always_comb
    begin
        if (oe_i)
            pin_seven_o = drive_i;
        else if (board_en_i)
            pin_seven_o = board_val_i;
        else
            pin_seven_o = ~last_q;
    end

    // remember the wire so a floating pin keeps changing
    always_ff @(posedge clock_i)
    begin
        last_q <= pin_seven_o;
    end

    assign low_pins_o = low_val_i;
endmodule : board_pins

`default_nettype wire

// file: verification/tb_top.sv
// self-checking bench of the port a pin logic
`include "porta_map.svh"
`default_nettype none

module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import porta_pkg::*;

    // ****************************************************************
    // signals and instances
    // ****************************************************************
    typedef struct {
        logic [7:0] mode, mask, c1d, data, frc;
        logic [2:0] lo;
        logic [3:0] pins;
        logic p7;
    } row_s;
    logic clock_i = 1'b0;
    logic resetn_i = 1'b0;
    logic ce_i = 1'b1;
    logic [4:0] addr = 5'h00;
    logic rd = 1'b0;
    logic wr = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic [3:0] be = 4'h1;
    logic [31:0] rdata;
    logic waitreq;
    logic c1m = 1'b0;
    logic [3:0] cxm = 4'h0;
    logic [2:0] cap;
    logic pa;
    logic [2:0] pin_in;
    logic [3:0] pin_out;
    logic p7_in;
    logic p7_out;
    logic p7_oe;
    logic board_en = 1'b0;
    logic board_val = 1'b0;
    logic [2:0] low_val = 3'h0;
    logic [31:0] q;
    int err_count = 0;
    int total_checks = 0;
    row_s rows [7] = '{
        '{8'h00, 8'h00, 8'h00, 8'h78, 8'h00, 3'h5, 4'hF, 1'b0},
        '{8'hFF, 8'h00, 8'h00, 8'h80, 8'h78, 3'h2, 4'hF, 1'b1},
        '{8'hAA, 8'h00, 8'h00, 8'h80, 8'h78, 3'h7, 4'h0, 1'b1},
        '{8'h55, 8'h00, 8'h00, 8'h80, 8'h78, 3'h0, 4'hF, 1'b1},
        '{8'h55, 8'h00, 8'h00, 8'h80, 8'h78, 3'h1, 4'h0, 1'b1},
        '{8'h55, 8'h78, 8'h50, 8'h80, 8'hF8, 3'h6, 4'hA, 1'b1},
        '{8'h00, 8'hA8, 8'h88, 8'h78, 8'h80, 3'h3, 4'hB, 1'b1}};

    port_a_timer_pin_logic dut (.clock_i(clock_i), .resetn_i(resetn_i), .ce_i(ce_i),
        .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata),
        .avs_byteenable_i(be), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
        .compare1_match_i(c1m), .compare_x_match_i(cxm), .capture_pin_o(cap),
        .pulse_accumulator_input_o(pa), .pin_in_i(pin_in), .pin_out_o(pin_out),
        .port_pin_seven_i(p7_in), .port_pin_seven_o(p7_out), .port_pin_seven_oe_o(p7_oe));

    board_pins board (.clock_i(clock_i), .drive_i(p7_out), .oe_i(p7_oe),
        .board_en_i(board_en), .board_val_i(board_val), .low_val_i(low_val),
        .pin_seven_o(p7_in), .low_pins_o(pin_in));

    // 40 MHz clock
    always #12.5 clock_i = ~clock_i;

    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    // one avalon access; entered just after a rising edge, held until waitrequest is low
    task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= {24'h0, d};
        wr <= w;
        rd <= ~w;
        do @(posedge clock_i); while (waitreq !== 1'b0);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clock_i);
    endtask : bus

    // n clock cycles; eight of them span two e-clock periods, enough for one port strobe to pass
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
    endtask : tick

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : test_done

    // ****************************************************************
    // tests
    // ****************************************************************
    // watchdog: the whole run needs well under a thousand cycles
    initial
    begin
        tick(5000);
        err_count++;
        test_done();
    end

    initial
    begin
        tick(4);
        check("reset oe", p7_oe, 1'b0);
        check("reset pins", pin_out, 4'h0);
        resetn_i <= 1'b1;
        @(posedge clock_i);
        bus(1'b1, `PA_OFF_DIR, 8'h80);
        foreach (rows[i])
        begin
            low_val <= rows[i].lo;
            bus(1'b1, `PA_OFF_MODE, rows[i].mode);
            bus(1'b1, `PA_OFF_C1MASK, rows[i].mask);
            bus(1'b1, `PA_OFF_C1DATA, rows[i].c1d);
            bus(1'b1, `PA_OFF_DATA, rows[i].data);
            bus(1'b1, `PA_OFF_FORCE, rows[i].frc);
            tick(8);
            check("pin_out", pin_out, rows[i].pins);
            check("pin7", p7_out, rows[i].p7);
            check("capture", cap, rows[i].lo);
            check("pulse acc", pa, rows[i].p7);
            bus(1'b0, `PA_OFF_DATA, 8'h00);
            check("data read", q, {rows[i].p7, rows[i].pins, rows[i].lo});
        end
        $display("row test done");
        // match pulses: own toggle, then compare1 beating a simultaneous match
        bus(1'b1, `PA_OFF_C1MASK, 8'h00);
        bus(1'b1, `PA_OFF_MODE, 8'h01);
        cxm <= 4'h3;
        @(posedge clock_i);
        cxm <= 4'h0;
        tick(8);
        check("match toggle", pin_out, 4'hE);
        bus(1'b1, `PA_OFF_C1MASK, 8'h08);
        bus(1'b1, `PA_OFF_C1DATA, 8'h00);
        c1m <= 1'b1;
        cxm <= 4'h1;
        @(posedge clock_i);
        c1m <= 1'b0;
        cxm <= 4'h0;
        tick(8);
        check("c1 wins", pin_out, 4'hE);
        $display("match test done");
        // pin 7 as input: latch still written, read shows the board level
        bus(1'b1, `PA_OFF_C1MASK, 8'h00);
        bus(1'b1, `PA_OFF_DIR, 8'h00);
        board_en <= 1'b1;
        board_val <= 1'b0;
        bus(1'b1, `PA_OFF_DATA, 8'h80);
        tick(8);
        check("oe off", p7_oe, 1'b0);
        bus(1'b0, `PA_OFF_DATA, 8'h00);
        check("pin7 read in", q[7], 1'b0);
        board_en <= 1'b0;
        bus(1'b1, `PA_OFF_DIR, 8'h80);
        tick(8);
        check("oe on", p7_oe, 1'b1);
        check("latched drive", p7_out, 1'b1);
        bus(1'b0, `PA_OFF_DATA, 8'h00);
        check("pin7 read out", q[7], 1'b1);
        $display("direction test done");
        // refused accesses
        be <= 4'h0;
        bus(1'b1, `PA_OFF_DATA, 8'h00);
        be <= 4'h1;
        tick(8);
        check("no byteenable", p7_out, 1'b1);
        bus(1'b0, 5'h1C, 8'h00);
        check("unmapped", q, 32'h0);
        bus(1'b0, `PA_OFF_FORCE, 8'h00);
        check("force reads", q, 32'h0);
        bus(1'b0, `PA_OFF_MODE, 8'h00);
        check("mode read", q, 32'h1);
        $display("refusal test done");
        // clock enable low must freeze the synchronizers, so a pin change stays unseen
        ce_i <= 1'b0;
        low_val <= 3'h6;
        tick(8);
        check("ce frozen cap", cap, 3'h3);
        check("ce frozen wait", waitreq, 1'b1);
        ce_i <= 1'b1;
        tick(8);
        check("ce resumed cap", cap, 3'h6);
        $display("clock enable test done");
        // second reset in mid-run
        resetn_i <= 1'b0;
        tick(2);
        check("rst wait", waitreq, 1'b1);
        check("rst oe", p7_oe, 1'b0);
        check("rst pin7", p7_out, 1'b0);
        resetn_i <= 1'b1;
        @(posedge clock_i);
        bus(1'b0, `PA_OFF_DIR, 8'h00);
        check("rst dir", q, 32'h0);
        bus(1'b0, `PA_OFF_MODE, 8'h00);
        check("rst mode", q, 32'h0);
        $display("reset test done");
        test_done();
    end
endmodule : tb_top

`default_nettype wire
